// [design/eas_seq.v]
// Event/action sequencer with AXI4-Lite register access
// ==========================================
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "eas_seq_regs.vh"
module eas_seq (
    input wire ref_clk,
    input wire srst,
    input wire onReference,
    output reg preset0Sel_r,
    output reg preset1Sel_r,
    output reg scanTick_r,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    input wire [7:0] s_axi_araddr,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp
);
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN = 2'b10;

    reg [1:0] state_r;
    reg modeOn_r;
    reg [4:0] pairCount_r;
    reg [31:0] tmrDur_r;
    reg [31:0] scanPeriod_r;
    reg [31:0] scanCnt_r;
    reg [4:0] index_r;
    reg [4:0] evMem [0:19];
    reg [4:0] actMem [0:19];
    reg [7:0] awAddr_r;
    reg awHave_r;
    reg [31:0] wData_r;
    reg [3:0] wStrb_r;
    reg wHave_r;
    reg tmrStart_r;
    wire tmrExpired;
    wire [4:0] curEv;
    wire [4:0] curAct;
    reg evTrue;
    integer i;

    // ==========================================
    // Helpers
    function isPair;
        input [7:0] a;
        begin
            isPair = (a >= `EAS_REG_PAIR0) && (a <= `EAS_REG_PAIR_LAST) && (a[1:0] == 2'b00);
        end
    endfunction

    function [4:0] pairIdx;
        input [7:0] a;
        reg [7:0] d;
        begin
            d = a - `EAS_REG_PAIR0;
            pairIdx = d[6:2];
        end
    endfunction

    function [31:0] mergeBytes;
        input [31:0] old;
        input [31:0] dat;
        input [3:0] strb;
        integer b;
        begin
            mergeBytes = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    mergeBytes[b*8 +: 8] = dat[b*8 +: 8];
                end
            end
        end
    endfunction

    // ==========================================
    // Scan strobe
    // periodic scan tick
    always @(posedge ref_clk) begin
        if (srst) begin
            scanCnt_r <= 32'h00000000;
            scanTick_r <= 1'b0;
        end else if (scanCnt_r + 32'h00000001 >= scanPeriod_r) begin
            scanCnt_r <= 32'h00000000;
            scanTick_r <= 1'b1;
        end else begin
            scanCnt_r <= scanCnt_r + 32'h00000001;
            scanTick_r <= 1'b0;
        end
    end

    // ==========================================
    // Condition decode
    assign curEv = evMem[index_r];
    assign curAct = actMem[index_r];

    always @* begin
        case (curEv)
            `EAS_EV_TRUE: evTrue = 1'b1;
            `EAS_EV_ONREF: evTrue = onReference;
            `EAS_EV_TMR0: evTrue = tmrExpired;
            default: evTrue = 1'b0;
        endcase
    end

    // ==========================================
    // Sequencer
    always @(posedge ref_clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            index_r <= 5'd0;
            preset0Sel_r <= 1'b0;
            preset1Sel_r <= 1'b0;
            tmrStart_r <= 1'b0;
        end else begin
            tmrStart_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    index_r <= 5'd0;
                    if (modeOn_r && pairCount_r != 5'd0) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!modeOn_r || pairCount_r == 5'd0) begin
                        state_r <= ST_IDLE;
                    end else if (scanTick_r && evTrue) begin
                        case (curAct)
                            `EAS_ACT_PRESET0: begin
                                preset0Sel_r <= 1'b1;
                                preset1Sel_r <= 1'b0;
                            end
                            `EAS_ACT_PRESET1: begin
                                preset0Sel_r <= 1'b0;
                                preset1Sel_r <= 1'b1;
                            end
                            `EAS_ACT_TMR0: tmrStart_r <= 1'b1;
                            default: ;
                        endcase
                        if (index_r + 5'd1 >= pairCount_r) begin
                            index_r <= 5'd0;
                        end else begin
                            index_r <= index_r + 5'd1;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    eas_timer uTimer (
        .refClk(ref_clk),
        .srst(srst),
        .start(tmrStart_r),
        .tick(scanTick_r),
        .duration(tmrDur_r),
        .expired_r(tmrExpired)
    );

    // ==========================================
    // AXI4-Lite write
    // Address and data may arrive in either order; both are held until the response
    always @(posedge ref_clk) begin
        if (srst) begin
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r <= 32'h00000000;
            wStrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `EAS_BRESP_OKAY;
            modeOn_r <= 1'b0;
            pairCount_r <= 5'd0;
            tmrDur_r <= `EAS_TMR_RST;
            scanPeriod_r <= `EAS_SCAN_RST;
            for (i = 0; i < 20; i = i + 1) begin
                evMem[i] <= `EAS_EV_FALSE;
                actMem[i] <= `EAS_ACT_NONE;
            end
        end else begin
            s_axi_awready <= !awHave_r && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !wHave_r && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (awHave_r && wHave_r && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `EAS_BRESP_OKAY;
                if (awAddr_r == `EAS_REG_CTRL) begin
                    if (wStrb_r[0]) modeOn_r <= wData_r[`EAS_CTRL_ON_BIT];
                end else if (awAddr_r == `EAS_REG_COUNT) begin
                    // Counts above the table size are clamped
                    if (wStrb_r[0]) begin
                        if (wData_r[7:0] > {3'b000, `EAS_MAX_PAIRS}) begin
                            pairCount_r <= `EAS_MAX_PAIRS;
                        end else begin
                            pairCount_r <= wData_r[4:0];
                        end
                    end
                end else if (awAddr_r == `EAS_REG_TMR) begin
                    tmrDur_r <= mergeBytes(tmrDur_r, wData_r, wStrb_r);
                end else if (awAddr_r == `EAS_REG_SCAN) begin
                    scanPeriod_r <= mergeBytes(scanPeriod_r, wData_r, wStrb_r);
                end else if (isPair(awAddr_r)) begin
                    if (wStrb_r[0]) evMem[pairIdx(awAddr_r)] <= wData_r[4:0];
                    if (wStrb_r[1]) actMem[pairIdx(awAddr_r)] <= wData_r[12:8];
                end else if (awAddr_r != `EAS_REG_STATUS && awAddr_r != `EAS_REG_INPUTS) begin
                    s_axi_bresp <= `EAS_BRESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                awHave_r <= 1'b0;
                wHave_r <= 1'b0;
            end
        end
    end

    // ==========================================
    // AXI4-Lite read
    always @(posedge ref_clk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `EAS_BRESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `EAS_BRESP_OKAY;
                if (s_axi_araddr == `EAS_REG_CTRL) begin
                    s_axi_rdata <= {31'h00000000, modeOn_r};
                end else if (s_axi_araddr == `EAS_REG_COUNT) begin
                    s_axi_rdata <= {27'h0000000, pairCount_r};
                end else if (s_axi_araddr == `EAS_REG_TMR) begin
                    s_axi_rdata <= tmrDur_r;
                end else if (s_axi_araddr == `EAS_REG_SCAN) begin
                    s_axi_rdata <= scanPeriod_r;
                end else if (s_axi_araddr == `EAS_REG_STATUS) begin
                    s_axi_rdata <= {19'h00000, index_r, 6'h00, state_r[1], tmrExpired};
                end else if (s_axi_araddr == `EAS_REG_INPUTS) begin
                    s_axi_rdata <= {29'h00000000, preset1Sel_r, preset0Sel_r, onReference};
                end else if (isPair(s_axi_araddr)) begin
                    s_axi_rdata <= {19'h00000, actMem[pairIdx(s_axi_araddr)], 3'b000,
                        evMem[pairIdx(s_axi_araddr)]};
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `EAS_BRESP_SLVERR;
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// [design/eas_seq_regs.vh]
// Register map, field codes and timing constants of the event/action sequencer
`ifndef EAS_SEQ_REGS_VH
`define EAS_SEQ_REGS_VH
// ==========================================
// Register offsets (byte addresses)
`define EAS_REG_CTRL 8'h00
`define EAS_REG_COUNT 8'h04
`define EAS_REG_TMR 8'h08
`define EAS_REG_SCAN 8'h0c
`define EAS_REG_STATUS 8'h10
`define EAS_REG_INPUTS 8'h14
`define EAS_REG_PAIR0 8'h40
`define EAS_REG_PAIR_LAST 8'h8c
// ==========================================
// Fields and limits
`define EAS_MAX_PAIRS 5'd20
`define EAS_CODE_W 5
`define EAS_CTRL_ON_BIT 0
`define EAS_PAIR_ACT_LSB 8
// ==========================================
// Condition codes
`define EAS_EV_FALSE 5'h00
`define EAS_EV_TRUE 5'h01
`define EAS_EV_ONREF 5'h04
`define EAS_EV_TMR0 5'h1e
// ==========================================
// Action codes
`define EAS_ACT_NONE 5'h01
`define EAS_ACT_PRESET0 5'h0a
`define EAS_ACT_PRESET1 5'h0b
`define EAS_ACT_TMR0 5'h1d
// ==========================================
// Reset values and timing
`define EAS_SCAN_RST 32'h00000c35
`define EAS_TMR_RST 32'h00000000
`define EAS_BRESP_OKAY 2'b00
`define EAS_BRESP_SLVERR 2'b10
`endif

// [design/eas_timer.v]
// Timer 0 of the sequencer: counts scan strobes after a start
`timescale 1ns/1ps
module eas_timer (
    input wire refClk,
    input wire srst,
    input wire start,
    input wire tick,
    input wire [31:0] duration,
    output reg expired_r
);
    reg [31:0] count_r;
    reg running_r;
    // ==========================================
    // Countdown
    // duration then expiry
    always @(posedge refClk) begin
        if (srst) begin
            count_r <= 32'h00000000;
            running_r <= 1'b0;
            expired_r <= 1'b0;
        end else if (start) begin
            // Restart clears an old expiry
            count_r <= duration;
            running_r <= 1'b1;
            expired_r <= 1'b0;
        end else if (running_r && tick) begin
            if (count_r <= 32'h00000001) begin
                running_r <= 1'b0;
                expired_r <= 1'b1;
            end else begin
                count_r <= count_r - 32'h00000001;
            end
        end
    end
endmodule

// [bench/eas_seq_sva.sv]
// Port assertions of the event/action sequencer
`timescale 1ns/1ps
module eas_seq_sva (
    input wire ref_clk,
    input wire srst,
    input wire preset0Sel_r,
    input wire preset1Sel_r,
    input wire scanTick_r,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    // ====
    // Sequencing
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    property p_tick; scanTick_r |=> !scanTick_r; endproperty
    a_tick: assert property (p_tick) else $error("strobe too long");
    property p_excl; !(preset0Sel_r && preset1Sel_r); endproperty
    a_excl: assert property (p_excl) else $error("both presets");
    property p_step0; $rose(preset0Sel_r) |-> $past(scanTick_r); endproperty
    a_step0: assert property (p_step0) else $error("preset 0 off strobe");
    property p_step1; $rose(preset1Sel_r) |-> $past(scanTick_r); endproperty
    a_step1: assert property (p_step1) else $error("preset 1 off strobe");
    // ====
    // Register bus
    property p_bdrop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_bdrop: assert property (p_bdrop) else $error("write answer stuck");
    property p_rdrop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_rdrop: assert property (p_rdrop) else $error("read answer stuck");
    property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_arblk: assert property (p_arblk) else $error("read taken early");
    property p_rans; s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    c_pre0: cover property ($rose(preset0Sel_r));
    c_pre1: cover property ($rose(preset1Sel_r));
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind eas_seq eas_seq_sva eas_seq_sva_i (.ref_clk(ref_clk), .srst(srst),
    .preset0Sel_r(preset0Sel_r), .preset1Sel_r(preset1Sel_r), .scanTick_r(scanTick_r),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// [bench/eas_drive_model.sv]
// Drive-side model: reports reaching the speed reference after a ramp
`timescale 1ns/1ps
module eas_drive_model (
    input wire ref_clk,
    input wire srst,
    input wire preset0Sel_r,
    input wire slow,
    output reg onReference = 1'b0
);
    reg [5:0] rampCnt_r = 6'h00;
    // ====
    // Ramp, slow or prompt
    // reference after ramp
    always @(posedge ref_clk) begin
        if (srst || !preset0Sel_r) begin
            rampCnt_r <= 6'h00;
            onReference <= 1'b0;
        end else if (rampCnt_r == (slow ? 6'h28 : 6'h02)) begin
            onReference <= 1'b1;
        end else begin
            rampCnt_r <= rampCnt_r + 6'h01;
        end
    end
endmodule

// [bench/eas_seq_bench.sv]
// Self-checking bench of the event/action sequencer
`timescale 1ns/1ps
module eas_seq_bench;
    reg ref_clk = 1'b0;
    reg srst = 1'b1;
    reg slow = 1'b1;
    reg awValid = 1'b0;
    reg wValid = 1'b0;
    reg bReady = 1'b0;
    reg arValid = 1'b0;
    reg rReady = 1'b0;
    reg [7:0] awAddr = 8'h00;
    reg [7:0] arAddr = 8'h00;
    reg [31:0] wData = 32'h0;
    reg [3:0] wStrb = 4'hf;
    reg [31:0] d;
    reg [7:0] pAddr;
    wire awReady, wReady, bValid, arReady, rValid, onRef, pre0, pre1, tick;
    wire [1:0] bResp, rResp;
    wire [31:0] rData;
    integer seed = 32'h9d0232a3;
    integer bad_count = 0;
    integer comparisons = 0;
    integer cyc = 0;
    integer i;
    integer gap;
    eas_seq eas_seq_i (.ref_clk(ref_clk), .srst(srst), .onReference(onRef),
        .preset0Sel_r(pre0), .preset1Sel_r(pre1), .scanTick_r(tick),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData),
        .s_axi_wstrb(wStrb), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_bresp(bResp), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_araddr(arAddr), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp));
    eas_drive_model eas_drive_model_i (.ref_clk(ref_clk), .srst(srst),
        .preset0Sel_r(pre0), .slow(slow), .onReference(onRef));
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    // ====
    // Checks and bus cycles
    task report_and_stop;
        begin
            if (bad_count == 0 && comparisons > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    task check(input [31:0] e, input [31:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("[ERR] %0t exp %h got %h", $time, e, g);
            end
        end
    endtask
    task chkResp(input [1:0] e, input [1:0] g);
        check({30'h0, e}, {30'h0, g});
    endtask
    // Status word: index in 12:8, running in 1, timer expiry in 0
    function [31:0] statusExp(input [4:0] idx, input run, input expd);
        begin
            statusExp = {19'h00000, idx, 6'h00, run, expd};
        end
    endfunction
    // Pair word keeps only the two five-bit codes
    function [31:0] pairExp(input [31:0] w);
        begin
            pairExp = {19'h00000, w[12:8], 3'b000, w[4:0]};
        end
    endfunction
    // Address and data offered together, each released when taken
    task wr(input [7:0] a, input [31:0] dd, input [1:0] er);
        reg pa;
        reg pw;
        begin
            @(posedge ref_clk);
            awValid <= 1'b1;
            wValid <= 1'b1;
            awAddr <= a;
            wData <= dd;
            bReady <= 1'b1;
            pa = 1'b1;
            pw = 1'b1;
            while (pa || pw) begin
                @(posedge ref_clk);
                if (pa && awReady === 1'b1) begin
                    pa = 1'b0;
                    awValid <= 1'b0;
                end
                if (pw && wReady === 1'b1) begin
                    pw = 1'b0;
                    wValid <= 1'b0;
                end
            end
            while (bValid !== 1'b1) @(posedge ref_clk);
            bReady <= 1'b0;
            chkResp(er, bResp);
        end
    endtask
    task rd(input [7:0] a, input [31:0] e, input [1:0] er);
        begin
            @(posedge ref_clk);
            arValid <= 1'b1;
            arAddr <= a;
            rReady <= 1'b1;
            do @(posedge ref_clk); while (arReady !== 1'b1);
            arValid <= 1'b0;
            while (rValid !== 1'b1) @(posedge ref_clk);
            rReady <= 1'b0;
            check(e, rData);
            chkResp(er, rResp);
        end
    endtask
    task waitPre(input which, input integer lim);
        integer n;
        begin
            n = 0;
            while ((which ? pre1 : pre0) !== 1'b1 && n < lim) begin
                @(posedge ref_clk);
                n = n + 1;
            end
            check(32'h1, {31'h0, which ? pre1 : pre0});
        end
    endtask
    // Hang guard, far above the few hundred cycles needed
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count = bad_count + 1;
            report_and_stop;
        end
    end
    // ====
    // Scenarios
    initial begin
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        rd(8'h0c, 32'hc35, 2'b00);
        rd(8'h04, 32'h0, 2'b00);
        wr(8'h0c, 32'h4, 2'b00);
        // Strobe spacing must follow the new period at once
        @(posedge ref_clk);
        while (tick !== 1'b1) @(posedge ref_clk);
        gap = 0;
        do begin
            @(posedge ref_clk);
            gap = gap + 1;
        end while (tick !== 1'b1 && gap < 20);
        check(32'h4, gap);
        wr(8'h08, 32'h3, 2'b00);
        // Lane 0 only: upper bytes must stay untouched
        wStrb <= 4'h1;
        wr(8'h08, 32'hffffff03, 2'b00);
        wStrb <= 4'hf;
        rd(8'h08, 32'h3, 2'b00);
        wr(8'h40, 32'h0a01, 2'b00);
        wr(8'h44, 32'h1d04, 2'b00);
        wr(8'h48, 32'h0b1e, 2'b00);
        wr(8'h4c, 32'h0100, 2'b00);
        wr(8'h04, 32'h4, 2'b00);
        wr(8'h00, 32'h1, 2'b00);
        waitPre(1'b0, 40);
        rd(8'h10, statusExp(5'd1, 1'b1, 1'b0), 2'b00);
        waitPre(1'b1, 200);
        rd(8'h10, statusExp(5'd3, 1'b1, 1'b1), 2'b00);
        repeat (20) @(posedge ref_clk);
        rd(8'h10, statusExp(5'd3, 1'b1, 1'b1), 2'b00);
        wr(8'h00, 32'h0, 2'b00);
        rd(8'h10, statusExp(5'd0, 1'b0, 1'b1), 2'b00);
        wr(8'h04, 32'd25, 2'b00);
        rd(8'h04, 32'd20, 2'b00);
        wr(8'h30, 32'h5, 2'b10);
        rd(8'h30, 32'h0, 2'b10);
        wr(8'h10, 32'hffff, 2'b00);
        rd(8'h10, statusExp(5'd0, 1'b0, 1'b1), 2'b00);
        for (i = 0; i < 20; i = i + 1) begin
            d = $random(seed);
            pAddr = 8'h40 + {i[5:0], 2'b00};
            wr(pAddr, d, 2'b00);
            rd(pAddr, pairExp(d), 2'b00);
        end
        slow <= 1'b0;
        wr(8'h40, 32'h0a01, 2'b00);
        wr(8'h44, 32'h0b04, 2'b00);
        // Third pair always true with no action, so the wrap passes a do-nothing step
        wr(8'h48, 32'h0101, 2'b00);
        wr(8'h04, 32'h3, 2'b00);
        wr(8'h00, 32'h1, 2'b00);
        waitPre(1'b0, 20);
        waitPre(1'b1, 20);
        repeat (5) @(posedge ref_clk);
        check(32'h1, {31'h0, pre1});
        check(32'h0, {31'h0, pre0});
        waitPre(1'b0, 20);
        report_and_stop;
    end
endmodule
